// *** dpa_alarm_unit.sv ***
// Dual programmable alarm unit, top level
//
// Functional notes
// - Upper control nibble selects alarm two source
// - Next nibble selects alarm one source
// - Alarm two may start event capture
// - Alarm one may start event capture
// - Indicator enable drives chosen digital line
// - Polarity bit sets indicator active level
// - Select bit picks line two or one
// - Threshold top bit picks compare direction
// - Low fourteen bits compared; bit fourteen unused
// - Sixteen-bit registers as two byte addresses
// - Alarms readable in status and indicator
// - Status bits nine and eight per alarm
// - Flags clear by command bit four only
`timescale 1ns/1ps
`include "dpa_defines.svh"
module dpa_alarm_unit
   import dpa_pkg::*;
#(
   parameter int DATA_W = 14
) (
   input  wire logic              CORE_CLK,
   input  wire logic              NRST,
   input  wire logic              REG_WR,
   input  wire logic              REG_RD,
   input  wire logic [7:0]        REG_ADDR,
   input  wire logic [7:0]        REG_WDATA,
   output logic      [7:0]        REG_RDATA,
   input  wire logic              SAMPLE_VALID,
   input  wire logic [DATA_W-1:0] SMP_SUPPLY,
   input  wire logic [DATA_W-1:0] SMP_XACC,
   input  wire logic [DATA_W-1:0] SMP_YACC,
   input  wire logic [DATA_W-1:0] SMP_AUX,
   input  wire logic [DATA_W-1:0] SMP_TEMP,
   input  wire logic [DATA_W-1:0] SMP_ROOT_SUM_SQUARE,
   output logic      [1:0]        ALARM_STATUS,
   output logic                   CAPTURE_START,
   output logic      [1:0]        CAPTURE_CAUSE,
   output logic                   DIGITAL_LINE_ONE_OUT,
   output logic                   DIGITAL_LINE_ONE_OE,
   output logic                   DIGITAL_LINE_TWO_OUT,
   output logic                   DIGITAL_LINE_TWO_OE
);

   ////////////////////////////////////////////////////////////////////////////
   // Parameter check

   if (DATA_W < 2 || DATA_W > 14) begin : g_bad_width
      $error("DATA_W must lie between 2 and 14");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Declarations

   logic [15:0] thr1;
   logic [15:0] thr2;
   logic [15:0] ctrl;
   logic [1:0]  hit;
   logic [1:0]  active;
   logic [1:0]  next_active;
   logic [1:0]  flag;
   logic [1:0]  next_flag;
   logic [1:0]  cause;
   logic [1:0]  next_cause;
   logic        capt;
   logic        next_capt;
   logic        clr;
   logic        ind_lvl;
   logic        d1o;
   logic        d1e;
   logic        d2o;
   logic        d2e;
   logic        next_d1o;
   logic        next_d1e;
   logic        next_d2o;
   logic        next_d2e;
   logic [7:0]  rdata;
   logic [7:0]  next_rdata;

   // Byte write strobe for one address
   function automatic logic wr_hit(input logic we, input logic [7:0] a,
                                   input logic [7:0] t);
      wr_hit = we && (a == t);
   endfunction : wr_hit

   ////////////////////////////////////////////////////////////////////////////
   // Registers reached by byte address

   // Threshold one
   dpa_breg #(
      .RST  (`DPA_RST_REG),
      .MASK (`DPA_MSK_THR)
   ) u_thr1 (
      .clk   (CORE_CLK),
      .nrst  (NRST),
      .wr_lo (wr_hit(REG_WR, REG_ADDR, `DPA_A_T1L)),
      .wr_hi (wr_hit(REG_WR, REG_ADDR, `DPA_A_T1H)),
      .wdata (REG_WDATA),
      .q     (thr1)
   );

   // Threshold two
   dpa_breg #(
      .RST  (`DPA_RST_REG),
      .MASK (`DPA_MSK_THR)
   ) u_thr2 (
      .clk   (CORE_CLK),
      .nrst  (NRST),
      .wr_lo (wr_hit(REG_WR, REG_ADDR, `DPA_A_T2L)),
      .wr_hi (wr_hit(REG_WR, REG_ADDR, `DPA_A_T2H)),
      .wdata (REG_WDATA),
      .q     (thr2)
   );

   // Control, all zero after reset
   dpa_breg #(
      .RST  (`DPA_RST_REG),
      .MASK (`DPA_MSK_CTL)
   ) u_ctrl (
      .clk   (CORE_CLK),
      .nrst  (NRST),
      .wr_lo (wr_hit(REG_WR, REG_ADDR, `DPA_A_CTL)),
      .wr_hi (wr_hit(REG_WR, REG_ADDR, `DPA_A_CTH)),
      .wdata (REG_WDATA),
      .q     (ctrl)
   );

   // Flag clear command
   assign clr = wr_hit(REG_WR, REG_ADDR, `DPA_A_CML) && REG_WDATA[`DPA_CMD_CLR];

   ////////////////////////////////////////////////////////////////////////////
   // Comparators

   // Alarm one
   dpa_cmp #(
      .DATA_W (DATA_W)
   ) u_cmp1 (
      .sel      (ctrl[`DPA_C_SRC1]),
      .thr      (thr1),
      .s_supply (SMP_SUPPLY),
      .s_xacc   (SMP_XACC),
      .s_yacc   (SMP_YACC),
      .s_aux    (SMP_AUX),
      .s_temp   (SMP_TEMP),
      .s_root_sum_square (SMP_ROOT_SUM_SQUARE),
      .hit      (hit[0])
   );

   // Alarm two
   dpa_cmp #(
      .DATA_W (DATA_W)
   ) u_cmp2 (
      .sel      (ctrl[`DPA_C_SRC2]),
      .thr      (thr2),
      .s_supply (SMP_SUPPLY),
      .s_xacc   (SMP_XACC),
      .s_yacc   (SMP_YACC),
      .s_aux    (SMP_AUX),
      .s_temp   (SMP_TEMP),
      .s_root_sum_square (SMP_ROOT_SUM_SQUARE),
      .hit      (hit[1])
   );

   ////////////////////////////////////////////////////////////////////////////
   // Evaluation, flags and capture start

   // Next alarm state
   always_comb begin
      next_active = active;
      if (SAMPLE_VALID) next_active = hit;
      // New alarm with its trigger armed starts capture
      next_cause = hit & ~active & {ctrl[`DPA_C_CAP2], ctrl[`DPA_C_CAP1]}
                   & {2{SAMPLE_VALID}};
      next_capt  = |next_cause;
      // Set wins over clear
      next_flag  = (flag & ~{2{clr}}) | (hit & {2{SAMPLE_VALID}});
   end

   // Alarm state registers
   always_ff @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         active <= 2'b00;
         flag   <= 2'b00;
         cause  <= 2'b00;
         capt   <= 1'b0;
      end else begin
         active <= next_active;
         flag   <= next_flag;
         cause  <= next_cause;
         capt   <= next_capt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Digital line indicator

   // Line enables and level
   always_comb begin
      ind_lvl  = (|active) ? ctrl[`DPA_C_IPOL] : ~ctrl[`DPA_C_IPOL];
      next_d1e = ctrl[`DPA_C_IEN] & ~ctrl[`DPA_C_ISEL];
      next_d2e = ctrl[`DPA_C_IEN] & ctrl[`DPA_C_ISEL];
      next_d1o = next_d1e ? ind_lvl : 1'b0;
      next_d2o = next_d2e ? ind_lvl : 1'b0;
   end

   // Line registers
   always_ff @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         d1o <= 1'b0;
         d1e <= 1'b0;
         d2o <= 1'b0;
         d2e <= 1'b0;
      end else begin
         d1o <= next_d1o;
         d1e <= next_d1e;
         d2o <= next_d2o;
         d2e <= next_d2e;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read port

   // Byte read mux, unmapped reads zero
   always_comb begin
      next_rdata = rdata;
      if (REG_RD) begin
         case (REG_ADDR)
            `DPA_A_T1L: next_rdata = thr1[7:0];
            `DPA_A_T1H: next_rdata = thr1[15:8];
            `DPA_A_T2L: next_rdata = thr2[7:0];
            `DPA_A_T2H: next_rdata = thr2[15:8];
            `DPA_A_CTL: next_rdata = ctrl[7:0];
            `DPA_A_CTH: next_rdata = ctrl[15:8];
            `DPA_A_STH: next_rdata = {6'b00_0000, flag};
            default:    next_rdata = 8'h00;
         endcase
      end
   end

   // Read data register
   always_ff @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) rdata <= 8'h00;
      else       rdata <= next_rdata;
   end

   // Outputs straight from flip-flops
   assign REG_RDATA     = rdata;
   assign ALARM_STATUS  = flag;
   assign CAPTURE_START = capt;
   assign CAPTURE_CAUSE = cause;
   assign DIGITAL_LINE_ONE_OUT = d1o;
   assign DIGITAL_LINE_ONE_OE  = d1e;
   assign DIGITAL_LINE_TWO_OUT = d2o;
   assign DIGITAL_LINE_TWO_OE  = d2e;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!NRST);

   // Control upper byte written then read back
   sequence s_wr_cth;
      REG_WR && !REG_RD && REG_ADDR == `DPA_A_CTH;
   endsequence
   sequence s_rd_cth;
      REG_RD && !REG_WR && REG_ADDR == `DPA_A_CTH;
   endsequence

   a_src2_off: assert property (SAMPLE_VALID && ctrl[15:12] == 4'h0 |=> !active[1])
      else $error("alarm two active with source disabled");
   a_src2_rootsum: assert property (SAMPLE_VALID && ctrl[15:12] == 4'h8 && thr2[15]
                                    && SMP_ROOT_SUM_SQUARE > thr2[DATA_W-1:0] |=> active[1])
      else $error("alarm two missed root sum square excess");
   a_src1_off: assert property (SAMPLE_VALID && ctrl[11:8] == 4'h7 |=> !active[0])
      else $error("alarm one active on unused source code");
   a_cap2_start: assert property (SAMPLE_VALID && hit[1] && !active[1] && ctrl[6]
                                  |=> CAPTURE_START && CAPTURE_CAUSE[1])
      else $error("alarm two did not start capture");
   a_cap1_gate: assert property (CAPTURE_CAUSE[0] |-> $past(ctrl[4]))
      else $error("alarm one started capture while disarmed");
   a_ind_off: assert property (!ctrl[2] |=> !DIGITAL_LINE_ONE_OE && !DIGITAL_LINE_TWO_OE)
      else $error("indicator line driven while disabled");
   a_ind_pol: assert property (ctrl[2] && !ctrl[0] && active == 2'b00
                               |=> DIGITAL_LINE_ONE_OE
                               && DIGITAL_LINE_ONE_OUT == !$past(ctrl[1]))
      else $error("idle indicator level wrong");
   a_ind_route: assert property (ctrl[2] && ctrl[0]
                                 |=> DIGITAL_LINE_TWO_OE && !DIGITAL_LINE_ONE_OE)
      else $error("indicator on wrong line");
   a_dir_less: assert property (SAMPLE_VALID && ctrl[11:8] == 4'h1 && !thr1[15]
                                && SMP_SUPPLY < thr1[DATA_W-1:0] |=> active[0])
      else $error("less-than alarm missed");
   a_thr_bit14: assert property (!thr1[14] && !thr2[14])
      else $error("unused threshold bit stored");
   a_byte_read: assert property (s_wr_cth ##1 s_rd_cth |=> REG_RDATA == $past(REG_WDATA, 2))
      else $error("control upper byte readback wrong");
   a_stat_read: assert property (REG_RD && REG_ADDR == `DPA_A_STH
                                 |=> REG_RDATA == {6'b00_0000, $past(flag)})
      else $error("status byte does not show flags");
   a_flag_hold: assert property (flag[1] && !clr |=> flag[1] [*1])
      else $error("alarm two flag dropped without clear");
   a_flag_clear: assert property (clr && !(SAMPLE_VALID && hit[0]) |=> !flag[0])
      else $error("alarm one flag not cleared");
   a_eval_hold: assert property (!SAMPLE_VALID |=> $stable(active))
      else $error("alarm state changed between samples");

endmodule : dpa_alarm_unit

// *** dpa_alarm_unit_bench.sv ***
// Self-checking testbench of the alarm unit
`timescale 1ns/1ps
module dpa_alarm_unit_bench;
   import dpa_pkg::*;

   logic              clk = 1'b0;
   logic              nrst = 1'b0;
   logic              wr;
   logic              rd;
   logic              sv = 1'b0;
   logic [7:0]        addr;
   logic [7:0]        wdata;
   logic [7:0]        rdata;
   logic [7:0]        rb;
   logic [13:0]       s [6];
   logic [1:0]        st;
   logic [1:0]        cause;
   logic              cs;
   logic              d1o;
   logic              d1e;
   logic              d2o;
   logic              d2e;
   int                n_mismatch = 0;
   int                checked = 0;
   localparam logic [3:0] CODES [6] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h8};
   localparam logic [7:0] CCTL [6] = '{8'h50, 8'h50, 8'h40, 8'h40, 8'h10, 8'h10};
   localparam logic [2:0] CEXP [6] = '{3'b011, 3'b101, 3'b000, 3'b101, 3'b011, 3'b000};
   localparam logic [7:0] UND [2] = '{8'h6F, 8'h97};

   // Clock, 50 ns period
   always #25 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////
   // Design and host model
   dpa_alarm_unit u_dpa_alarm_unit (
      .CORE_CLK(clk), .NRST(nrst), .REG_WR(wr), .REG_RD(rd), .REG_ADDR(addr),
      .REG_WDATA(wdata), .REG_RDATA(rdata), .SAMPLE_VALID(sv),
      .SMP_SUPPLY(s[0]), .SMP_XACC(s[1]), .SMP_YACC(s[2]), .SMP_AUX(s[3]),
      .SMP_TEMP(s[4]), .SMP_ROOT_SUM_SQUARE(s[5]), .ALARM_STATUS(st),
      .CAPTURE_START(cs), .CAPTURE_CAUSE(cause), .DIGITAL_LINE_ONE_OUT(d1o),
      .DIGITAL_LINE_ONE_OE(d1e), .DIGITAL_LINE_TWO_OUT(d2o),
      .DIGITAL_LINE_TWO_OE(d2e)
   );
   dpa_host_model u_dpa_host_model (
      .clk(clk), .wr(wr), .rd(rd), .addr(addr), .wdata(wdata), .rdata(rdata)
   );

   ////////////////////////////////////////////////////////////////////////
   // Compare, access and sample tasks
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic w(input logic [7:0] a, input logic [7:0] d);
      u_dpa_host_model.put(a, d);
   endtask : w

   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      u_dpa_host_model.get(a, rb);
      chk("register byte", e, rb);
   endtask : rdchk

   // Clear latched flags through the command byte
   task automatic clr();
      w(8'h3E, 8'h10);
   endtask : clr

   // One sample set, only source i nonzero; returns after the taking edge
   task automatic pulse(input int i, input logic [13:0] v);
      @(negedge clk);
      foreach (s[k]) s[k] = 14'h0000;
      s[i] = v;
      sv = 1'b1;
      @(negedge clk);
      sv = 1'b0;
   endtask : pulse

   function automatic logic [7:0] dio_exp(input logic [2:0] c, input logic act);
      logic lvl;
      lvl = act ? c[1] : ~c[1];
      dio_exp = {4'h0, c[2] & c[0], c[2] & c[0] & lvl, c[2] & ~c[0], c[2] & ~c[0] & lvl};
   endfunction : dio_exp

   task automatic close_out();
      $display("mismatches %0d comparisons %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : close_out

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      foreach (s[k]) s[k] = 14'h0000;
      repeat (12) @(negedge clk);
      nrst = 1'b1;
      foreach (CCTL[k]) rdchk(8'h20 + 8'(k), 8'h00);
      rdchk(8'h28, 8'h00);
      rdchk(8'h29, 8'h00);
      rdchk(8'h30, 8'h00);
      w(8'h29, 8'h23);
      w(8'h28, 8'hFF);
      rdchk(8'h29, 8'h23);
      rdchk(8'h28, 8'h57);
      u_dpa_host_model.put_get(8'h29, 8'h45, rb);
      chk("register byte", 8'h45, rb);
      w(8'h28, 8'h00);
      u_dpa_host_model.put16(8'h20, 16'h8064);
      u_dpa_host_model.put16(8'h22, 16'h8064);
      // Every source code on both alarms, greater than 100
      for (int a = 0; a < 2; a++) begin
         for (int i = 0; i < 6; i++) begin
            w(8'h29, a ? {CODES[i], 4'h0} : {4'h0, CODES[i]});
            pulse(i, 14'd200);
            chk("status", 8'(a + 1), {6'h00, st});
            clr();
            chk("status", 8'h00, {6'h00, st});
            pulse(i, 14'd100);
            chk("status", 8'h00, {6'h00, st});
            pulse((i + 1) % 6, 14'd200);
            chk("status", 8'h00, {6'h00, st});
         end
      end
      // Undefined codes never alarm
      foreach (UND[u]) begin
         w(8'h29, UND[u]);
         for (int i = 0; i < 6; i++) begin
            pulse(i, 14'd200);
            chk("status", 8'h00, {6'h00, st});
         end
      end
      // Less-than direction and signed source format
      w(8'h29, 8'h02);
      u_dpa_host_model.put16(8'h20, 16'h0064);
      pulse(1, 14'd50);
      chk("status", 8'h01, {6'h00, st});
      clr();
      pulse(1, 14'h3FF0);
      chk("status", 8'h01, {6'h00, st});
      clr();
      u_dpa_host_model.put16(8'h20, 16'hFFF6);
      rdchk(8'h21, 8'hBF);
      pulse(1, 14'd5);
      chk("status", 8'h01, {6'h00, st});
      pulse(1, 14'h3FE0);
      rdchk(8'h3D, 8'h01);
      rdchk(8'h3C, 8'h00);
      clr();
      rdchk(8'h3D, 8'h00);
      pulse(1, 14'd5);
      clr();
      chk("status", 8'h00, {6'h00, st});
      pulse(1, 14'd5);
      chk("status", 8'h01, {6'h00, st});
      // Capture triggers, alarm two on Y and alarm one on X
      w(8'h29, 8'h32);
      u_dpa_host_model.put16(8'h20, 16'h8064);
      pulse(0, 14'd0);
      foreach (CCTL[j]) begin
         w(8'h28, CCTL[j]);
         pulse(1 + (j % 2), 14'd200);
         chk("capture", {5'h00, CEXP[j]}, {5'h00, cause, cs});
      end
      // Indicator enable, polarity and line select; lines hold no other job
      for (int c = 0; c < 8; c++) begin
         w(8'h28, 8'(c));
         for (int act = 0; act < 2; act++) begin
            pulse(1, act ? 14'd200 : 14'd0);
            @(negedge clk);
            chk("indicator", dio_exp(3'(c), act[0]), {4'h0, d2e, d2o, d1e, d1o});
         end
      end
      close_out();
   end

   // Watchdog against a hung sequence
   initial begin
      #400us;
      n_mismatch++;
      close_out();
   end

endmodule : dpa_alarm_unit_bench

// *** dpa_breg.sv ***
// Sixteen-bit register written as two bytes
`timescale 1ns/1ps
module dpa_breg #(
   parameter logic [15:0] RST  = 16'h0000,
   parameter logic [15:0] MASK = 16'hFFFF
) (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        wr_lo,
   input  wire logic        wr_hi,
   input  wire logic [7:0]  wdata,
   output logic      [15:0] q
);
   logic [15:0] next_q;

   // Byte lane merge, unused bits forced low
   always_comb begin
      next_q = q;
      if (wr_lo) next_q[7:0] = wdata & MASK[7:0];
      if (wr_hi) next_q[15:8] = wdata & MASK[15:8];
   end

   // Storage
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) q <= RST;
      else       q <= next_q;
   end
endmodule : dpa_breg

// *** dpa_cmp.sv ***
// Alarm source select and threshold compare
`timescale 1ns/1ps
`include "dpa_defines.svh"
module dpa_cmp
   import dpa_pkg::*;
#(
   parameter int DATA_W = 14
) (
   input  wire logic [3:0]        sel,
   input  wire logic [15:0]       thr,
   input  wire logic [DATA_W-1:0] s_supply,
   input  wire logic [DATA_W-1:0] s_xacc,
   input  wire logic [DATA_W-1:0] s_yacc,
   input  wire logic [DATA_W-1:0] s_aux,
   input  wire logic [DATA_W-1:0] s_temp,
   input  wire logic [DATA_W-1:0] s_root_sum_square,
   output logic                   hit
);
   logic [DATA_W-1:0] smp;
   logic [DATA_W-1:0] sa;
   logic [DATA_W-1:0] ta;
   logic [DATA_W-1:0] flip;
   logic              ok;

   // Source mux, compare in the source's own format
   always_comb begin
      ok  = 1'b1;
      smp = '0;
      case (sel)
         DPA_SRC_SUPPLY: smp = s_supply;
         DPA_SRC_XACC:   smp = s_xacc;
         DPA_SRC_YACC:   smp = s_yacc;
         DPA_SRC_AUX:    smp = s_aux;
         DPA_SRC_TEMP:   smp = s_temp;
         DPA_SRC_ROOT_SUM_SQUARE: smp = s_root_sum_square;
         default:        ok  = 1'b0;
      endcase
      // Offset binary makes signed order match unsigned order
      flip = {dpa_src_signed(sel), {(DATA_W-1){1'b0}}};
      sa   = smp ^ flip;
      ta   = thr[DATA_W-1:0] ^ flip;
      hit  = ok & (thr[`DPA_T_DIR] ? (sa > ta) : (sa < ta));
   end
endmodule : dpa_cmp

// *** dpa_defines.svh ***
// Register offsets, field positions and reset values of the alarm unit
`ifndef DPA_DEFINES_SVH
`define DPA_DEFINES_SVH
// Byte addresses
`define DPA_A_T1L    8'h20
`define DPA_A_T1H    8'h21
`define DPA_A_T2L    8'h22
`define DPA_A_T2H    8'h23
`define DPA_A_CTL    8'h28
`define DPA_A_CTH    8'h29
`define DPA_A_STL    8'h3C
`define DPA_A_STH    8'h3D
`define DPA_A_CML    8'h3E
`define DPA_A_CMH    8'h3F
// Control fields
`define DPA_C_SRC2   15:12
`define DPA_C_SRC1   11:8
`define DPA_C_CAP2   6
`define DPA_C_CAP1   4
`define DPA_C_IEN    2
`define DPA_C_IPOL   1
`define DPA_C_ISEL   0
// Threshold fields
`define DPA_T_DIR    15
// Status bits in the upper status byte
`define DPA_S_ALM2   1
`define DPA_S_ALM1   0
// Command bit that clears latched flags
`define DPA_CMD_CLR  4
// Reset values and writable masks
`define DPA_RST_REG  16'h0000
`define DPA_MSK_CTL  16'hFF57
`define DPA_MSK_THR  16'hBFFF
`endif

// *** dpa_host_model.sv ***
// Host side model driving the byte-wide register port of the alarm unit
`timescale 1ns/1ps
module dpa_host_model (
   input  wire logic       clk,
   output logic            wr,
   output logic            rd,
   output logic      [7:0] addr,
   output logic      [7:0] wdata,
   input  wire logic [7:0] rdata
);

   // Idle bus at time zero
   initial begin
      wr = 1'b0;
      rd = 1'b0;
      addr = 8'hFF;
      wdata = 8'hFF;
   end

   ////////////////////////////////////////////////////////////////////////
   // One byte write, strobe held over exactly one rising edge
   task automatic put(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      wr = 1'b1;
      addr = a;
      wdata = d;
      @(negedge clk);
      wr = 1'b0;
      addr = ~a; // Released lines carry no stale value
      wdata = ~d;
   endtask : put

   // Sixteen-bit value as two byte writes, upper byte first
   task automatic put16(input logic [7:0] a, input logic [15:0] d);
      put(a + 8'h01, d[15:8]);
      put(a, d[7:0]);
   endtask : put16

   // One byte read, data taken at the edge after the read edge
   task automatic get(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      rd = 1'b1;
      addr = a;
      @(negedge clk);
      rd = 1'b0;
      addr = ~a;
      d = rdata;
   endtask : get

   // Byte write followed at the very next edge by a read of the same byte
   task automatic put_get(input logic [7:0] a, input logic [7:0] v, output logic [7:0] d);
      @(negedge clk);
      wr = 1'b1;
      addr = a;
      wdata = v;
      @(negedge clk);
      wr = 1'b0;
      rd = 1'b1;
      @(negedge clk);
      rd = 1'b0;
      addr = ~a;
      wdata = ~v;
      d = rdata;
   endtask : put_get

endmodule : dpa_host_model

// *** dpa_pkg.sv ***
// Types and shared helpers of the alarm unit
package dpa_pkg;

   // Source selector codes
   typedef enum logic [3:0] {
      DPA_SRC_OFF             = 4'h0,
      DPA_SRC_SUPPLY          = 4'h1,
      DPA_SRC_XACC            = 4'h2,
      DPA_SRC_YACC            = 4'h3,
      DPA_SRC_AUX             = 4'h4,
      DPA_SRC_TEMP            = 4'h5,
      DPA_SRC_ROOT_SUM_SQUARE = 4'h8
   } dpa_src_t;

   // Two's complement sources
   function automatic logic dpa_src_signed(input logic [3:0] code);
      case (code)
         DPA_SRC_XACC, DPA_SRC_YACC, DPA_SRC_TEMP: dpa_src_signed = 1'b1;
         default:                                  dpa_src_signed = 1'b0;
      endcase
   endfunction : dpa_src_signed

endpackage : dpa_pkg
